//--- verilog/cgd_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Each write carries an 8-bit address split into a 4-bit group selector and 4-bit index.
// - Selector zero hits all 40 channels; otherwise bit0..bit3 enable groups A..D in any mix.
// - The index picks register 0 to 9 inside each selected group.
// - With all channels selected the index is ignored and every channel is written.
// - After power-up the outputs sit cleared at the device-under-test ground level.
// - A 2-bit type select picks data 11, offset 10, gain 01 or special function 00.
// - Address and 14-bit data are latched on the write strobe rising edge with select low.
module cgd_decoder (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        dev_sel_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [13:0] data_i,
	input  wire logic        register_type_select_high_i,
	input  wire logic        register_type_select_low_i,
	output logic [39:0]      ch_sel_o,
	output logic [13:0]      wr_data_o,
	output logic [1:0]       reg_type_o,
	output logic             special_function_o,
	output logic             wr_stb_o,
	output logic             output_clear_o
);
	// ==========================================================
	// Pin synchronisation
	// Every pin is asynchronous to mclk_i, so each one passes two flops
	// before any decode logic reads it
	logic [7:0]  addr_s1_reg;
	logic [7:0]  addr_s2_reg;
	logic [13:0] data_s1_reg;
	logic [13:0] data_s2_reg;
	logic [1:0]  type_s1_reg;
	logic [1:0]  type_s2_reg;
	logic        sel_n_s;
	logic        wr_n_s;
	logic        wr_n_d_reg;

	// Select pin idles high, so its synchroniser resets to the idle level
	cgd_sync2 u_sync_sel (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n_i),
		.rst_val_i (cgd_pkg::PIN_IDLE),
		.d_i       (dev_sel_n_i),
		.q_o       (sel_n_s)
	);

	// Strobe pin idles high too; a low reset value would fake a rising edge
	cgd_sync2 u_sync_wr (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n_i),
		.rst_val_i (cgd_pkg::PIN_IDLE),
		.d_i       (wr_n_i),
		.q_o       (wr_n_s)
	);

	// Address lines, aligned with the strobe synchroniser
	// The host holds the bus steady for several cycles around the strobe
	// rise, so a word-wide capture needs no handshake of its own
	// Limitation: a host that changes the bus within one cycle of the
	// rise can have a mixed word latched
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_s1_reg <= cgd_pkg::ADDR_RST;
			addr_s2_reg <= cgd_pkg::ADDR_RST;
		end else begin
			addr_s1_reg <= addr_i;
			addr_s2_reg <= addr_s1_reg;
		end
	end

	// Data lines, same depth as the address path
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_s1_reg <= cgd_pkg::DATA_RST;
			data_s2_reg <= cgd_pkg::DATA_RST;
		end else begin
			data_s1_reg <= data_i;
			data_s2_reg <= data_s1_reg;
		end
	end

	// Register-type lines, same depth as the address path
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			type_s1_reg <= cgd_pkg::TYPE_RST;
			type_s2_reg <= cgd_pkg::TYPE_RST;
		end else begin
			type_s1_reg <= {register_type_select_high_i, register_type_select_low_i};
			type_s2_reg <= type_s1_reg;
		end
	end

	// Previous strobe level for edge detection
	// Reset to the idle level, so no false edge follows reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_n_d_reg <= cgd_pkg::PIN_IDLE;
		end else begin
			wr_n_d_reg <= wr_n_s;
		end
	end

	// ==========================================================
	// Decode
	// Latency from pin rise to strobe is three edges: two for the
	// synchroniser and one for the outputs; the edge detector adds none
	logic            write_edge;
	logic [3:0]      gsel;
	logic [3:0]      idx;
	logic            bcast;
	logic            idx_ok;
	logic [9:0]      reg_onehot;
	logic [3:0][9:0] grp_sel;
	logic [39:0]     ch_sel_next;
	logic            special_next;

	// Rising strobe edge
	// Select is looked at on the edge itself; a rise with select high is dropped
	assign write_edge = wr_n_s && !wr_n_d_reg && !sel_n_s;

	assign gsel = addr_s2_reg[cgd_pkg::ADDR_W-1:cgd_pkg::GSEL_LSB];
	assign idx  = addr_s2_reg[cgd_pkg::GSEL_LSB-1:0];

	// Selector zero is the broadcast code
	assign bcast = (gsel == cgd_pkg::GSEL_ALL);

	// Index above 9 selects no register
	assign idx_ok = (idx <= cgd_pkg::IDX_LAST);

	// One register line out of ten
	// An index outside the range leaves every line low
	always_comb begin
		reg_onehot = cgd_pkg::SLICE_NONE;
		for (int n = 0; n < cgd_pkg::REGS_PER_G; n++) begin
			if (idx_ok && (int'(idx) == n)) begin
				reg_onehot[n] = 1'b1;
			end
		end
	end

	// Group slices, broadcast overrides the index
	// A selector with several bits set writes the same register in each
	// chosen group; the slices are independent, so one generate loop does
	for (genvar g = 0; g < cgd_pkg::GROUPS; g++) begin : g_group
		assign grp_sel[g] = bcast ? cgd_pkg::SLICE_ALL :
			(gsel[g] ? reg_onehot : cgd_pkg::SLICE_NONE);
	end

	// Group A in the low slice, so register n of group g is bit g*10+n
	assign ch_sel_next = grp_sel;

	// Special function type flag
	// Decoded once here so the output flop needs no compare of its own
	assign special_next = (type_s2_reg == cgd_pkg::TYPE_SPECIAL);

	// ==========================================================
	// Output registers
	// Every output comes straight from a flop; all load on the same edge,
	// so a reader never sees half of one write and half of another

	// One-cycle strobe per write
	// It pulses even when the index selects nothing, so the host side
	// can count every accepted write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_stb_o <= cgd_pkg::FLAG_RST;
		end else begin
			wr_stb_o <= write_edge;
		end
	end

	// Channel select, held until the next write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ch_sel_o <= cgd_pkg::CH_SEL_RST;
		end else if (write_edge) begin
			ch_sel_o <= ch_sel_next;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_data_o <= cgd_pkg::DATA_RST;
		end else if (write_edge) begin
			wr_data_o <= data_s2_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_type_o <= cgd_pkg::TYPE_RST;
		end else if (write_edge) begin
			reg_type_o <= type_s2_reg;
		end
	end

	// Special function flag of the write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			special_function_o <= cgd_pkg::FLAG_RST;
		end else if (write_edge) begin
			special_function_o <= special_next;
		end
	end

	// Clear held from reset until the first write lands
	// A later reset brings it back, so outputs never drive stale codes
	// Trade-off: any accepted write drops the clear, not only a data write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			output_clear_o <= cgd_pkg::CLEAR_RST;
		end else if (write_edge) begin
			output_clear_o <= ~cgd_pkg::CLEAR_RST;
		end
	end
endmodule

//--- verilog/cgd_pkg.sv
package cgd_pkg;

	// ==========================================================
	// Geometry
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 14;
	localparam int unsigned GROUPS     = 4;
	localparam int unsigned REGS_PER_G = 10;
	localparam int unsigned CHANNELS   = 40;
	localparam int unsigned GSEL_LSB   = 4;
	localparam int unsigned IDX_W      = 4;
	localparam int unsigned TYPE_W     = 2;

	// ==========================================================
	// Codes
	localparam logic [3:0] GSEL_ALL      = 4'h0;
	localparam logic [3:0] IDX_LAST      = 4'h9;
	localparam logic [1:0] TYPE_DATA     = 2'h3;
	localparam logic [1:0] TYPE_OFFSET   = 2'h2;
	localparam logic [1:0] TYPE_GAIN     = 2'h1;
	localparam logic [1:0] TYPE_SPECIAL  = 2'h0;
	localparam logic [9:0] SLICE_ALL     = 10'h3ff;
	localparam logic [9:0] SLICE_NONE    = 10'h000;

	// ==========================================================
	// Reset values
	localparam logic [39:0] CH_SEL_RST  = 40'h00_0000_0000;
	localparam logic [13:0] DATA_RST    = 14'h0000;
	localparam logic [1:0]  TYPE_RST    = 2'h0;
	localparam logic [7:0]  ADDR_RST    = 8'h00;
	localparam logic        FLAG_RST    = 1'b0;
	localparam logic        CLEAR_RST   = 1'b1;
	localparam logic        PIN_IDLE    = 1'b1;

endpackage

//--- verilog/cgd_sync2.sv
`timescale 1ns/1ps

// ==========================================================
// Two-flop synchroniser for one pin
module cgd_sync2 (
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic rst_val_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= cgd_pkg::PIN_IDLE;
			q_o      <= cgd_pkg::PIN_IDLE;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

	// rst_val_i kept unused in flops: async reset takes a constant
	logic unused_rst_val;
	assign unused_rst_val = rst_val_i;
endmodule

//--- tb/cgd_host.sv
`timescale 1ns/1ps
// ==========
// Host write port model
module cgd_host (
	output logic        cs_n_o,
	output logic        wr_n_o,
	output logic [7:0]  addr_o,
	output logic [13:0] data_o,
	output logic [1:0]  type_o,
	input  wire logic   mclk_i
);
	initial {cs_n_o, wr_n_o, addr_o, data_o, type_o} = 26'h3ffffff;
	task automatic wr(input logic s, input logic [7:0] a, input logic [13:0] d, input logic [1:0] t);
		@(negedge mclk_i);
		{cs_n_o, wr_n_o, addr_o, data_o, type_o} = {s, 1'b0, a, d, t};
		repeat (4) @(negedge mclk_i);
		wr_n_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		// Inverse on release so stale values never pass
		{cs_n_o, addr_o, data_o, type_o} = {1'b1, ~a, ~d, ~t};
	endtask
endmodule

//--- tb/cgd_decoder_sva.sv
`timescale 1ns/1ps
// ==========
// Port checker
module cgd_decoder_sva (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [13:0] data_i,
	input wire logic        register_type_select_high_i,
	input wire logic        register_type_select_low_i,
	input wire logic [39:0] ch_sel_o,
	input wire logic [13:0] wr_data_o,
	input wire logic [1:0]  reg_type_o,
	input wire logic        special_function_o,
	input wire logic        wr_stb_o,
	input wire logic        output_clear_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0]  addr_d1_reg;
	logic [7:0]  addr_d2_reg;
	logic [39:0] exp_sel;
	// Address two edges back, still inside the hold window
	always_ff @(posedge mclk_i) {addr_d2_reg, addr_d1_reg} <= {addr_d1_reg, addr_i};
	assign exp_sel = (addr_d2_reg[7:4] == 4'h0) ? {40{1'b1}} :
		{{10{addr_d2_reg[7]}}, {10{addr_d2_reg[6]}},
		{10{addr_d2_reg[5]}}, {10{addr_d2_reg[4]}}} & {4{10'h1 << addr_d2_reg[3:0]}};
	chk_stb_single: assert property (wr_stb_o |=> !wr_stb_o)
		else $error("strobe too wide");
	chk_data_latch: assert property (wr_stb_o |-> wr_data_o == $past(data_i, 2))
		else $error("data wrong");
	chk_type_latch: assert property (wr_stb_o |-> reg_type_o ==
		{$past(register_type_select_high_i, 2), $past(register_type_select_low_i, 2)})
		else $error("type wrong");
	chk_special_flag: assert property (wr_stb_o |->
		special_function_o == (reg_type_o == 2'h0))
		else $error("special flag wrong");
	chk_all_chans: assert property (wr_stb_o && addr_d2_reg[7:4] == 4'h0 |-> &ch_sel_o)
		else $error("broadcast wrong");
	chk_group_mask: assert property (wr_stb_o && addr_d2_reg[3:0] <= 4'h9 |->
		ch_sel_o == exp_sel)
		else $error("group mask wrong");
	chk_idx_range: assert property (wr_stb_o && addr_d2_reg[7:4] != 4'h0 &&
		addr_d2_reg[3:0] > 4'h9 |-> ch_sel_o == 40'h00_0000_0000)
		else $error("index over 9 selected");
	chk_clear_release: assert property ($fell(output_clear_o) |-> wr_stb_o)
		else $error("clear left early");
	chk_sel_hold: assert property (!wr_stb_o |-> $stable(ch_sel_o))
		else $error("select moved");
endmodule
bind cgd_decoder cgd_decoder_sva u_sva (.mclk_i, .rst_n_i, .addr_i, .data_i,
	.register_type_select_high_i, .register_type_select_low_i, .ch_sel_o, .wr_data_o,
	.reg_type_o, .special_function_o, .wr_stb_o, .output_clear_o);

//--- tb/tb_dac_channel_group_address_decoder.sv
`timescale 1ns/1ps
// ==========
// Bench
module tb_dac_channel_group_address_decoder;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	wire         dev_sel_n_i, wr_n_i, register_type_select_high_i, register_type_select_low_i;
	wire  [7:0]  addr_i;
	wire  [13:0] data_i;
	logic [39:0] ch_sel_o;
	logic [13:0] wr_data_o;
	logic [1:0]  reg_type_o;
	logic        special_function_o, wr_stb_o, output_clear_o;
	logic [56:0] q[$];
	int          num_errors = 0;
	int          checks_done = 0;
	initial forever #4 mclk_i = ~mclk_i;
	cgd_host host (.cs_n_o(dev_sel_n_i), .wr_n_o(wr_n_i), .addr_o(addr_i), .data_o(data_i),
		.type_o({register_type_select_high_i, register_type_select_low_i}), .mclk_i);
	cgd_decoder DUT (.mclk_i, .rst_n_i, .dev_sel_n_i, .wr_n_i, .addr_i, .data_i,
		.register_type_select_high_i, .register_type_select_low_i, .ch_sel_o, .wr_data_o,
		.reg_type_o, .special_function_o, .wr_stb_o, .output_clear_o);
	task automatic chk(input string n, input logic [56:0] e, input logic [56:0] s);
		checks_done++;
		if (e !== s) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// Note the expected outputs, then let the host write
	task automatic wr(input logic s, input logic [7:0] x, input logic [13:0] d, input logic [1:0] t);
		if (!s)
			q.push_back({((x[7:4] == 4'h0) ? {40{1'b1}} : {{10{x[7]}}, {10{x[6]}}, {10{x[5]}},
				{10{x[4]}}} & {4{10'h1 << x[3:0]}}), d, t, t == 2'h0});
		host.wr(s, x, d, t);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Each strobe retires the oldest note; a strobe with none is refused traffic leaking
	always @(negedge mclk_i) if (rst_n_i && wr_stb_o === 1'b1) begin
		if (q.size() == 0)
			chk("spurious strobe", 57'h0, 57'h1);
		else
			chk("write", q.pop_front(), {ch_sel_o, wr_data_o, reg_type_o, special_function_o});
	end
	initial begin
		void'($urandom(54));
		repeat (6) @(negedge mclk_i);
		rst_n_i = 1'b1;
		chk("reset", 57'h1, 57'({ch_sel_o, output_clear_o}));
		// Broadcast, top index, index over 9, mixed groups, refused select, each type
		wr(1'b0, 8'h00, 14'h3fff, 2'h3);
		chk("clear", 57'h0, 57'(output_clear_o));
		wr(1'b0, 8'h0f, 14'h0001, 2'h2);
		wr(1'b0, 8'h19, 14'h2aaa, 2'h1);
		wr(1'b0, 8'hfa, 14'h1555, 2'h0);
		wr(1'b1, 8'h11, 14'h0f0f, 2'h3);
		for (int n = 0; n < 16; n++)
			wr(1'b0, 8'($urandom), 14'($urandom), n[1:0]);
		// Mid-run reset brings the clear back; a two-group write drops it again
		@(negedge mclk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		chk("reset again", 57'h1, 57'({ch_sel_o, output_clear_o}));
		rst_n_i = 1'b1;
		wr(1'b0, 8'h35, 14'h0abc, 2'h3);
		chk("clear again", 57'h0, 57'(output_clear_o));
		for (int k = 0; k < 20 && q.size() != 0; k++)
			@(negedge mclk_i);
		chk("pending", 57'h0, 57'(q.size()));
		tally_and_finish();
	end
endmodule
